// ==== acr_analog_readout.sv ====
// Local design decisions: the address map and register access over APB.
`default_nettype none
module anr_analog_readout
	import anr_pkg::*;
(
	input wire logic pclk,                  // bus clock
	input wire logic presetn,               // async reset, active low
	input wire logic [7:0] paddr,           // APB address
	input wire logic psel,                  // APB select
	input wire logic penable,               // APB enable
	input wire logic pwrite,                // APB direction
	input wire logic [31:0] pwdata,         // APB write data
	output logic [31:0] prdata,             // APB read data
	output logic pready,                    // APB ready
	output logic pslverr,                   // APB error
	output logic adc_req,                   // conversion request pulse
	output logic [4:0] adc_req_chan,        // channel to convert
	input wire logic adc_valid,             // result valid
	input wire logic [4:0] adc_chan,        // result channel
	input wire logic [11:0] adc_data,       // result value
	output logic adc_ready,                 // result accepted
	input wire logic [15:0] measured_velocity_source, // servo velocity
	input wire logic [15:0] torque_source,  // servo torque
	input wire logic [31:0] pos_err_in      // servo position error
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r, rd_data;
	logic addr_ok, apb_fire, wr_cmd;
	logic [7:0] cmd_r;
	logic [15:0] chan_param_r, filt_param_r;
	logic cfg_act_r, cfg_ext_r, refused_r;
	logic [4:0] cfg_chan_r;
	logic [11:0] cfg_coef_r;
	logic [2:0] cfg_dest_r;
	logic single_pend_r;
	logic [4:0] single_chan_r;
	logic [2:0] single_dest_r;
	logic [10:0] tick_cnt_r;
	logic tick_r;
	logic scan_run_r;
	logic [4:0] scan_cnt_r;
	logic adc_req_r;
	logic [4:0] adc_req_chan_r;
	logic [16:0] filt_mem [0:CHANNELS-1];
	logic signed [15:0] user_mem [0:USER_REGS-1];
	anr_state_t state_r, state_nxt;
	logic sel_single_r, load_cont, load_single;
	logic cur_ext_r;
	logic [4:0] cur_chan_r;
	logic [11:0] cur_coef_r;
	logic [2:0] cur_dest_r;
	logic signed [15:0] src_r, src_val, out_r, lp_val, prev;
	logic [11:0] filt_sel;
	logic signed [16:0] lp_diff;
	logic signed [29:0] lp_prod;
	logic [16:0] f_old, f_new, f_in;
	logic signed [17:0] f_diff;
	logic [1:0] op_w;
	logic [3:0] bch_w;
	logic [4:0] xch_w;

	anr_stream_if #(.W(BUF_W)) adc_s ();
	anr_stream_if #(.W(BUF_W)) eng_s ();

	function automatic logic is_analog(input logic [4:0] c);
		is_analog = !(c == CH_OFF || c == CH_VELOCITY || c == CH_TORQUE || c == CH_POS_ERR ||
			c == CH_RSV_A || c == CH_RSV_B || c > CH_MAX_EXT);
	endfunction

	// ----------------------------------------------------------------
	// APB slave, one wait state
	// ----------------------------------------------------------------
	assign apb_fire = psel && penable && pready_r;
	assign wr_cmd = apb_fire && pwrite && addr_ok && (paddr == OFF_CMD);
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	always_comb begin
		rd_data = 32'h0;
		addr_ok = 1'b0;
		if (paddr[1:0] == 2'h0) begin
			if (paddr == OFF_CMD) begin
				addr_ok = 1'b1;
				rd_data = {24'h0, cmd_r};
			end else if (paddr == OFF_CHAN_PARAM) begin
				addr_ok = 1'b1;
				rd_data = {16'h0, chan_param_r};
			end else if (paddr == OFF_FILT_PARAM) begin
				addr_ok = 1'b1;
				rd_data = {16'h0, filt_param_r};
			end else if (paddr == OFF_STATUS) begin
				addr_ok = !pwrite;
				rd_data[ST_ACT_BIT] = cfg_act_r;
				rd_data[ST_EXT_BIT] = cfg_ext_r;
				rd_data[ST_SINGLE_BIT] = single_pend_r;
				rd_data[ST_REFUSED_BIT] = refused_r;
				rd_data[ST_BUSY_BIT] = (state_r != ST_IDLE);
				rd_data[ST_CHAN_LSB +: 5] = cfg_chan_r;
			end else if ((paddr & USER_MASK) == OFF_USER_BASE) begin
				addr_ok = !pwrite;
				rd_data = {16'h0, user_mem[paddr[4:2]]};
			end else if ((paddr & CHAN_MASK) == OFF_CHAN_BASE) begin
				addr_ok = !pwrite;
				rd_data = {20'h0, filt_mem[paddr[6:2]][16:FILT_FRAC]};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= psel && penable && !pready_r;
			if (psel && penable && !pready_r) begin
				pslverr_r <= !addr_ok;
				prdata_r <= pwrite ? 32'h0 : rd_data;
			end else begin
				pslverr_r <= 1'b0;
				prdata_r <= 32'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_r <= RST_CMD;
			chan_param_r <= RST_PARAM;
			filt_param_r <= RST_PARAM;
		end else if (apb_fire && pwrite && addr_ok) begin
			if (paddr == OFF_CMD) begin
				cmd_r <= pwdata[7:0];
			end
			if (paddr == OFF_CHAN_PARAM) begin
				chan_param_r <= pwdata[15:0];
			end
			if (paddr == OFF_FILT_PARAM) begin
				filt_param_r <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign op_w = pwdata[CMD_OP_LSB +: 2];
	assign bch_w = chan_param_r[BCH_LSB +: 4];
	assign xch_w = chan_param_r[XCH_LSB +: 5];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_act_r <= 1'b0;
			cfg_ext_r <= 1'b0;
			cfg_chan_r <= CH_OFF;
			cfg_coef_r <= 12'h000;
			cfg_dest_r <= 3'h0;
			refused_r <= 1'b0;
		end else if (wr_cmd && op_w == OP_BASIC) begin
			cfg_act_r <= (bch_w != 4'h0);
			cfg_ext_r <= 1'b0;
			cfg_chan_r <= {1'b0, bch_w};
			cfg_coef_r <= chan_param_r[COEF_LSB +: 12];
			cfg_dest_r <= pwdata[CMD_DEST_LSB +: 3];
			refused_r <= 1'b0;
		end else if (wr_cmd && op_w == OP_EXT) begin
			// Reserved or out-of-range codes switch the copy off
			cfg_act_r <= (xch_w != CH_OFF) && (xch_w <= CH_MAX_EXT) &&
				(xch_w != CH_RSV_A) && (xch_w != CH_RSV_B);
			cfg_ext_r <= 1'b1;
			cfg_chan_r <= xch_w;
			cfg_coef_r <= filt_param_r[COEF_LSB +: 12];
			cfg_dest_r <= pwdata[CMD_DEST_LSB +: 3];
			refused_r <= (xch_w > CH_MAX_EXT) || (xch_w == CH_RSV_A) || (xch_w == CH_RSV_B);
		end else if (wr_cmd) begin
			refused_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_pend_r <= 1'b0;
			single_chan_r <= CH_OFF;
			single_dest_r <= 3'h0;
		end else if (wr_cmd && op_w == OP_SINGLE && bch_w != 4'h0) begin
			// A new request wins over the clear of the one just served
			single_pend_r <= 1'b1;
			single_chan_r <= {1'b0, bch_w};
			single_dest_r <= pwdata[CMD_DEST_LSB +: 3];
		end else if (state_r == ST_WRITE && sel_single_r) begin
			single_pend_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Servo tick and background scan
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 11'h000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 11'(TICK_CYC - 1));
			tick_cnt_r <= (tick_cnt_r == 11'(TICK_CYC - 1)) ? 11'h000 : 11'(tick_cnt_r + 11'h001);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_run_r <= 1'b0;
			scan_cnt_r <= 5'h00;
			adc_req_r <= 1'b0;
			adc_req_chan_r <= 5'h00;
		end else begin
			if (tick_r) begin
				scan_run_r <= 1'b1;
				scan_cnt_r <= 5'h01;
			end else if (scan_run_r) begin
				scan_run_r <= (scan_cnt_r != CH_MAX_EXT);
				scan_cnt_r <= 5'(scan_cnt_r + 5'h01);
			end
			adc_req_r <= scan_run_r && is_analog(scan_cnt_r);
			adc_req_chan_r <= scan_cnt_r;
		end
	end
	assign adc_req = adc_req_r;
	assign adc_req_chan = adc_req_chan_r;

	// ----------------------------------------------------------------
	// Result buffer and background filter
	// ----------------------------------------------------------------
	assign adc_s.valid = adc_valid;
	assign adc_s.data = {adc_chan, adc_data};
	assign adc_ready = adc_s.ready;

	anr_pair_buf #(.W(BUF_W)) u_buf (
		.clk(pclk),
		.rst_n(presetn),
		.in_s(adc_s),
		.out_s(eng_s)
	);

	// Filter memory is shared with the copy path, so results wait while a copy runs
	assign eng_s.ready = (state_r == ST_IDLE);
	assign f_old = filt_mem[eng_s.data[16:12]];
	assign f_in = {eng_s.data[11:0], 5'h00};
	assign f_diff = $signed({1'b0, f_in}) - $signed({1'b0, f_old});
	assign f_new = 17'($signed({1'b0, f_old}) + (f_diff >>> FILT_SHIFT));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				filt_mem[i] <= 17'h00000;
			end
		end else if (eng_s.valid && eng_s.ready) begin
			filt_mem[eng_s.data[16:12]] <= f_new;
		end
	end

	// ----------------------------------------------------------------
	// Copy engine
	// ----------------------------------------------------------------
	assign load_cont = (state_r == ST_IDLE) && tick_r && cfg_act_r;
	assign load_single = ((state_r == ST_IDLE) && tick_r && !cfg_act_r && single_pend_r) ||
		((state_r == ST_WRITE) && !sel_single_r && single_pend_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (load_cont || load_single) begin
					state_nxt = ST_COPY;
				end
			end
			ST_COPY: begin
				state_nxt = ST_FILT;
			end
			ST_FILT: begin
				state_nxt = ST_WRITE;
			end
			ST_WRITE: begin
				state_nxt = load_single ? ST_COPY : ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			sel_single_r <= 1'b0;
			cur_ext_r <= 1'b0;
			cur_chan_r <= CH_OFF;
			cur_coef_r <= 12'h000;
			cur_dest_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			if (load_cont) begin
				sel_single_r <= 1'b0;
				cur_ext_r <= cfg_ext_r;
				cur_chan_r <= cfg_chan_r;
				cur_coef_r <= cfg_coef_r;
				cur_dest_r <= cfg_dest_r;
			end else if (load_single) begin
				sel_single_r <= 1'b1;
				cur_ext_r <= 1'b0;
				cur_chan_r <= single_chan_r;
				cur_coef_r <= 12'h000;
				cur_dest_r <= single_dest_r;
			end
		end
	end

	assign filt_sel = filt_mem[cur_chan_r][16:FILT_FRAC];
	always_comb begin
		case (cur_chan_r)
			CH_VELOCITY: src_val = measured_velocity_source;
			CH_TORQUE: src_val = torque_source;
			CH_POS_ERR: begin
				if ($signed(pos_err_in) > POS_MAX) begin
					src_val = 16'sh7FFF;
				end else if ($signed(pos_err_in) < POS_MIN) begin
					src_val = 16'sh8000;
				end else begin
					src_val = pos_err_in[15:0];
				end
			end
			default: begin
				if (cur_ext_r) begin
					src_val = {4'h0, filt_sel} << EXT_SHIFT;
				end else begin
					src_val = {6'h00, filt_sel[11:2]} << BASIC_SHIFT;
				end
			end
		endcase
	end

	// Optional extra low-pass against the destination's last value
	assign prev = user_mem[cur_dest_r];
	assign lp_diff = $signed({src_r[15], src_r}) - $signed({prev[15], prev});
	assign lp_prod = lp_diff * $signed({1'b0, cur_coef_r});
	assign lp_val = 16'(prev + 16'(lp_prod >>> COEF_FRAC));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r <= 16'sh0000;
			out_r <= 16'sh0000;
		end else begin
			if (state_r == ST_COPY) begin
				src_r <= src_val;
			end
			if (state_r == ST_FILT) begin
				out_r <= (cur_coef_r == 12'h000) ? src_r : lp_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < USER_REGS; i++) begin
				user_mem[i] <= 16'sh0000;
			end
		end else if (state_r == ST_WRITE) begin
			user_mem[cur_dest_r] <= out_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [11:0] gap_r;
	logic seen_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r <= 12'h000;
			seen_r <= 1'b0;
		end else begin
			gap_r <= tick_r ? 12'h000 : 12'(gap_r + 12'h001);
			seen_r <= seen_r || tick_r;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_tick;
		tick_r && seen_r |-> gap_r == 12'(TICK_CYC - 1);
	endproperty
	a_tick: assert property (p_tick) else $error("tick spacing wrong");

	property p_copy_start;
		tick_r && cfg_act_r && state_r == ST_IDLE |=> state_r == ST_COPY ##2 state_r == ST_WRITE;
	endproperty
	a_copy_start: assert property (p_copy_start) else $error("tick copy missed");

	property p_replace;
		wr_cmd && op_w == OP_BASIC |=> cfg_chan_r == {1'b0, $past(bch_w)} && !cfg_ext_r;
	endproperty
	a_replace: assert property (p_replace) else $error("basic config not replaced");

	property p_coef;
		wr_cmd && op_w == OP_BASIC |=> cfg_coef_r == $past(chan_param_r[15:4]);
	endproperty
	a_coef: assert property (p_coef) else $error("basic coefficient wrong");

	property p_bg;
		eng_s.valid && eng_s.ready |-> state_r == ST_IDLE;
	endproperty
	a_bg: assert property (p_bg) else $error("filter write during copy");

	property p_basic_scale;
		state_r == ST_COPY && !cur_ext_r && is_analog(cur_chan_r) |=>
			src_r[4:0] == 5'h00 && src_r <= 16'sh7FE0;
	endproperty
	a_basic_scale: assert property (p_basic_scale) else $error("basic scale wrong");

	property p_ext_scale;
		state_r == ST_COPY && cur_ext_r && is_analog(cur_chan_r) |=>
			src_r[2:0] == 3'h0 && src_r <= 16'sh7FF8;
	endproperty
	a_ext_scale: assert property (p_ext_scale) else $error("extended scale wrong");

	property p_single;
		state_r == ST_WRITE && sel_single_r && !wr_cmd |=> !single_pend_r;
	endproperty
	a_single: assert property (p_single) else $error("single read repeated");

	property p_reserved;
		wr_cmd && op_w == OP_EXT && (xch_w == CH_RSV_A || xch_w == CH_RSV_B) |=>
			!cfg_act_r && refused_r;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code accepted");

	property p_sat;
		state_r == ST_COPY && cur_chan_r == CH_POS_ERR && $signed(pos_err_in) > POS_MAX |=>
			src_r == 16'sh7FFF;
	endproperty
	a_sat: assert property (p_sat) else $error("position error not saturated");
endmodule
`default_nettype wire

// ==== acr_pkg.sv ====
`default_nettype none
package anr_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_CHAN_PARAM = 8'h04;
	localparam logic [7:0] OFF_FILT_PARAM = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_USER_BASE = 8'h40;
	localparam logic [7:0] USER_MASK = 8'hE0;
	localparam logic [7:0] OFF_CHAN_BASE = 8'h80;
	localparam logic [7:0] CHAN_MASK = 8'h80;
	localparam int USER_REGS = 8;
	localparam int CHANNELS = 32;
	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DEST_LSB = 4;
	localparam int BCH_LSB = 0;
	localparam int COEF_LSB = 4;
	localparam int XCH_LSB = 0;
	localparam int ST_ACT_BIT = 0;
	localparam int ST_EXT_BIT = 1;
	localparam int ST_SINGLE_BIT = 2;
	localparam int ST_REFUSED_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_CHAN_LSB = 8;
	localparam logic [15:0] RST_PARAM = 16'h0000;
	localparam logic [7:0] RST_CMD = 8'h00;
	// ----------------------------------------------------------------
	// Channel codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CH_OFF = 5'h00;
	localparam logic [4:0] CH_VELOCITY = 5'h0D;
	localparam logic [4:0] CH_TORQUE = 5'h0E;
	localparam logic [4:0] CH_POS_ERR = 5'h0F;
	localparam logic [4:0] CH_RSV_A = 5'h1A;
	localparam logic [4:0] CH_RSV_B = 5'h1B;
	localparam logic [4:0] CH_MAX_EXT = 5'h1C;
	// ----------------------------------------------------------------
	// Scaling and filtering
	// ----------------------------------------------------------------
	localparam int BASIC_SHIFT = 5;
	localparam int EXT_SHIFT = 3;
	localparam int COEF_FRAC = 12;
	localparam int FILT_FRAC = 5;
	// One sample per channel per tick; 2^5 ticks gives a lag in the 4 ms range
	localparam int FILT_SHIFT = 5;
	localparam int FILT_TAU_NS = 5000000;
	localparam logic signed [31:0] POS_MAX = 32'sh00007FFF;
	localparam logic signed [31:0] POS_MIN = 32'shFFFF8000;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int TICK_NS = 120000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUF_W = 17;
	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_BASIC = 2'h1,
		OP_SINGLE = 2'h2,
		OP_EXT = 2'h3
	} anr_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_COPY = 2'h1,
		ST_FILT = 2'h3,
		ST_WRITE = 2'h2
	} anr_state_t;
endpackage
`default_nettype wire

// ==== acr_stream_if.sv ====
`default_nettype none
interface anr_stream_if #(parameter int W = 17);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== acr_pair_buf.sv ====
`default_nettype none
module anr_pair_buf #(parameter int W = 17) (
	input wire logic clk,           // clock
	input wire logic rst_n,         // async reset, active low
	anr_stream_if.snk in_s,         // filling side
	anr_stream_if.src out_s         // draining side
);
	logic [W-1:0] mem [0:1];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic ready_r;
	logic push;
	logic pop;

	assign push = in_s.valid && ready_r;
	assign pop = out_s.valid && out_s.ready;
	assign in_s.ready = ready_r;
	assign out_s.valid = (cnt_r != 2'h0);
	assign out_s.data = mem[rd_ptr_r];

	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = 2'(cnt_r + 2'h1);
		end else if (pop && !push) begin
			cnt_nxt = 2'(cnt_r - 2'h1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			ready_r <= 1'b0;
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			// Registered ready from the next count: a full buffer refuses the source in the same cycle
			ready_r <= (cnt_nxt != 2'h2);
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_s.data;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_buf_full;
		cnt_r == 2'h2 |-> !in_s.ready;
	endproperty
	a_buf_full: assert property (p_buf_full) else $error("full buffer still ready");

	property p_buf_hold;
		out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("stalled word changed");
endmodule
`default_nettype wire

// ==== acr_adc_model.sv ====
`default_nettype none
module anr_adc_model (
	input wire logic clk, // converter clock
	input wire logic rst_n, // async reset, active low
	input wire logic req, // conversion request
	input wire logic [4:0] req_chan, // channel asked for
	output logic valid, // result valid
	output logic [4:0] chan, // result channel
	output logic [11:0] data, // result value
	input wire logic ready // result taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] q[$];
	logic [4:0] c;
	int cnt[32];
	// ----
	// Converter: fixed value per channel, random answer delay
	// ----
	// Idle data is the inverse of the last word, so stale data never looks valid
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid <= 1'b0;
			chan <= 5'h00;
			data <= 12'h000;
			q.delete();
			foreach (cnt[i]) cnt[i] = 0;
		end else begin
			if (req) q.push_back(req_chan);
			if (valid && ready) begin
				valid <= 1'b0;
				data <= ~data;
				cnt[chan]++;
			end else if (!valid && q.size() > 0 && $urandom % 2) begin
				c = q.pop_front();
				valid <= 1'b1;
				chan <= c;
				data <= {c, 7'h55};
			end
		end
	end
endmodule
`default_nettype wire

// ==== acr_analog_readout_test.sv ====
`default_nettype none
module anr_analog_readout_test
	import anr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic adc_req, adc_valid, adc_ready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, perr;
	logic [4:0] adc_req_chan, adc_chan;
	logic [11:0] adc_data;
	logic [15:0] vel, trq, v0;
	int miscompares, compares, f;
	int xc[4] = '{26, 27, 29, 28};
	anr_analog_readout dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_req(adc_req), .adc_req_chan(adc_req_chan),
		.adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data), .adc_ready(adc_ready),
		.measured_velocity_source(vel), .torque_source(trq), .pos_err_in(perr));
	anr_adc_model adc (.clk(pclk), .rst_n(presetn), .req(adc_req), .req_chan(adc_req_chan),
		.valid(adc_valid), .chan(adc_chan), .data(adc_data), .ready(adc_ready));
	// ----
	// Bus and checking tasks
	// ----
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// Lands mid-interval, well after the copy and the scan of the latest tick
	task automatic sync();
		while (adc_req !== 1'b1) begin
			@(posedge pclk);
		end
		repeat (600) @(posedge pclk);
	endtask
	function automatic int filt(int x, int n);
		int y;
		y = 0;
		repeat (n) y = y + ((x * 32 - y) >>> 5);
		return y >>> 5;
	endfunction
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (40000) @(posedge pclk);
		miscompares++;
		give_verdict();
	end
	initial begin
		{psel, penable, pwrite, presetn, paddr, pwdata, vel, trq, perr} = '0;
		miscompares = 0;
		compares = 0;
		void'($urandom(1));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(OFF_STATUS, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OFF_STATUS, 32'hFF);
		chk({31'h0, er}, 32'h1);
		$display("test reset done");
		vel <= 16'($urandom);
		trq <= 16'($urandom);
		apb(1'b1, OFF_CHAN_PARAM, 32'h0D);
		apb(1'b1, OFF_CMD, 32'h21);
		sync();
		rdchk(OFF_USER_BASE + 8'h08, {16'h0, vel});
		rdchk(OFF_STATUS, 32'h00000D01);
		v0 = vel;
		vel <= 16'($urandom);
		apb(1'b1, OFF_CHAN_PARAM, 32'h0E);
		apb(1'b1, OFF_FILT_PARAM, 32'h0);
		apb(1'b1, OFF_CMD, 32'h33);
		sync();
		rdchk(OFF_USER_BASE + 8'h0C, {16'h0, trq});
		rdchk(OFF_USER_BASE + 8'h08, {16'h0, v0});
		perr <= 32'h00012345;
		apb(1'b1, OFF_CHAN_PARAM, 32'h0F);
		apb(1'b1, OFF_CMD, 32'h43);
		sync();
		rdchk(OFF_USER_BASE + 8'h10, 32'h00007FFF);
		perr <= 32'hFFFE7960;
		sync();
		rdchk(OFF_USER_BASE + 8'h10, 32'h00008000);
		$display("test continuous done");
		foreach (xc[i]) begin
			apb(1'b1, OFF_CHAN_PARAM, 32'(xc[i]));
			apb(1'b1, OFF_CMD, 32'h03);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd & 32'h9, (i < 3) ? 32'h8 : 32'h1);
		end
		apb(1'b1, OFF_CHAN_PARAM, 32'h0);
		apb(1'b1, OFF_CMD, 32'h01);
		apb(1'b1, OFF_CMD, 32'h0);
		apb(1'b1, OFF_CHAN_PARAM, 32'h0E);
		apb(1'b1, OFF_CMD, 32'h12);
		rdchk(OFF_STATUS, 32'h00000004);
		sync();
		rdchk(OFF_USER_BASE + 8'h04, {16'h0, trq});
		v0 = trq;
		trq <= 16'($urandom);
		sync();
		rdchk(OFF_USER_BASE + 8'h04, {16'h0, v0});
		$display("test single done");
		apb(1'b1, OFF_CHAN_PARAM, 32'h04);
		apb(1'b1, OFF_CMD, 32'h51);
		sync();
		f = adc.cnt[4];
		rdchk(OFF_CHAN_BASE + 8'h10, 32'(filt(12'h255, f)));
		rdchk(OFF_USER_BASE + 8'h14, 32'((filt(12'h255, f - 1) >> 2) << 5));
		apb(1'b1, OFF_CMD, 32'h53);
		sync();
		f = adc.cnt[4];
		rdchk(OFF_USER_BASE + 8'h14, 32'(filt(12'h255, f - 1) << 3));
		f = adc.cnt[20];
		rdchk(OFF_CHAN_BASE + 8'h50, 32'(filt(12'hA55, f)));
		$display("test scaling done");
		apb(1'b1, OFF_CHAN_PARAM, 32'h800D);
		apb(1'b1, OFF_CMD, 32'h61);
		sync();
		f = (int'($signed(vel)) * 2048) >>> 12;
		rdchk(OFF_USER_BASE + 8'h18, {16'h0, 16'(f)});
		apb(1'b1, OFF_FILT_PARAM, 32'hC000);
		apb(1'b1, OFF_CHAN_PARAM, 32'h0D);
		apb(1'b1, OFF_CMD, 32'h63);
		sync();
		f = f + (((int'($signed(vel)) - f) * 3072) >>> 12);
		rdchk(OFF_USER_BASE + 8'h18, {16'h0, 16'(f)});
		$display("test filter done");
		give_verdict();
	end
endmodule
`default_nettype wire
